/* File: rtl/wwd_pkg.sv */
/*
 window watchdog package: register offsets, field layouts, reset values,
 key values and timing constants shared by the watchdog design.
 assumes a classic wishbone slave with 32-bit data and byte addresses.
*/
// Summary of operation
// - watchdog count is a 12-bit down counter behind an 8-bit prescaler with a 3-bit divide select.
// - counter underflow without a prior reload raises a system reset request.
// - reload while count exceeds delta is a violation and raises system reset.
// - software programs the delta value that bounds the reload window.
// - an option holds the counter while the processor is halted in debug.
// - once enabled, write protection blocks writes to configuration registers.
// - counting clock comes from the low-speed internal or external oscillator.
package wwd_pkg;
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_RELOAD = 8'h04;
   localparam logic [7:0] ADDR_DELTA = 8'h08;
   localparam logic [7:0] ADDR_KICK = 8'h0C;
   localparam logic [7:0] ADDR_PROT = 8'h10;
   localparam logic [7:0] ADDR_COUNT = 8'h14;
   localparam logic [7:0] ADDR_STAT = 8'h18;
   localparam logic [7:0] ADDR_MASK = 8'h1C;
   localparam int CNT_W = 12;
   localparam int PRE_W = 3;
   localparam int CTRL_EN = 0;
   localparam int CTRL_DBG_HOLD = 1;
   localparam int CTRL_SRC_EXT = 2;
   localparam int CTRL_PRE_LO = 4;
   localparam int ST_UNDER = 0;
   localparam int ST_EARLY = 1;
   localparam logic [15:0] KICK_KEY = 16'h5FA0;
   localparam logic [15:0] PROT_LOCK_KEY = 16'hCA35;
   localparam logic [15:0] PROT_UNLOCK_KEY = 16'h35CA;
   localparam logic [11:0] RELOAD_RST = 12'hFFF;
   localparam logic [11:0] DELTA_RST = 12'hFFF;
   localparam logic [2:0] PRE_RST = 3'h0;
   localparam logic [1:0] MASK_RST = 2'h3;
   localparam int RST_PULSE_NS = 400;
   localparam int CLK_NS = 40;
   localparam int RST_PULSE_CYC = (RST_PULSE_NS + CLK_NS - 1) / CLK_NS;
   typedef struct packed {
      logic [2:0] pre_sel;
      logic src_ext;
      logic dbg_hold;
      logic en;
   } wwd_ctrl_t;
   typedef struct packed {
      logic early;
      logic under;
   } wwd_evt_t;
endpackage

/* File: rtl/wwd_top.sv */
/*
 window watchdog with wishbone slave, sticky status, mask and interrupt.
 assumes the low-speed oscillator clocks arrive as plain pins and are
 sampled on clk; the system reset controller consumes sys_rst_req.
*/
`timescale 1ns/1ps
module wwd_top (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // oscillators and debug
   input wire logic low_speed_internal_osc,
   input wire logic low_speed_external_osc,
   input wire logic cpu_halted,
   // outputs
   output logic sys_rst_req,
   output logic irq
);
   ////////////////////////////////////////////////////////////////////////
   wwd_pkg::wwd_ctrl_t ctrl;
   wwd_pkg::wwd_evt_t stat;
   wwd_pkg::wwd_evt_t mask;
   logic [11:0] reload;
   logic [11:0] delta;
   logic [11:0] count;
   logic [7:0] pre_cnt;
   logic locked;
   logic [1:0] int_sync;
   logic [1:0] ext_sync;
   logic [1:0] halt_sync;
   logic osc_prev;
   logic [3:0] pulse_cnt;
   logic wr;
   logic rd_en;
   logic kick;
   logic osc_lvl;
   logic osc_edge;
   logic tick;
   logic early;
   logic under;
   logic [7:0] pre_lim;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // bus decode
   // writes land at the edge where the master samples ack high
   assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
   assign rd_en = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign kick = wr && hit(wb_adr_i, wwd_pkg::ADDR_KICK)
      && wb_sel_i[1] && wb_dat_i[15:0] == wwd_pkg::KICK_KEY;
   assign early = kick && (count > delta);
   assign under = tick && ctrl.en && (count == 12'h000);

   always_ff @(posedge clk) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (rd_en) begin
         case (wb_adr_i)
            wwd_pkg::ADDR_CTRL: wb_dat_o <= {25'h0, ctrl.pre_sel, 1'b0,
               ctrl.src_ext, ctrl.dbg_hold, ctrl.en};
            wwd_pkg::ADDR_RELOAD: wb_dat_o <= {20'h0, reload};
            wwd_pkg::ADDR_DELTA: wb_dat_o <= {20'h0, delta};
            wwd_pkg::ADDR_PROT: wb_dat_o <= {31'h0, locked};
            wwd_pkg::ADDR_COUNT: wb_dat_o <= {20'h0, count};
            wwd_pkg::ADDR_STAT: wb_dat_o <= {30'h0, stat};
            wwd_pkg::ADDR_MASK: wb_dat_o <= {30'h0, mask};
            default: wb_dat_o <= 32'h0000_0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // configuration, write protected
   always_ff @(posedge clk) begin
      if (rst) begin
         locked <= 1'b0;
      end else if (wr && hit(wb_adr_i, wwd_pkg::ADDR_PROT) && wb_sel_i[1]) begin
         if (wb_dat_i[15:0] == wwd_pkg::PROT_LOCK_KEY) begin
            locked <= 1'b1;
         end else if (wb_dat_i[15:0] == wwd_pkg::PROT_UNLOCK_KEY) begin
            locked <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl <= '0;
         ctrl.pre_sel <= wwd_pkg::PRE_RST;
         reload <= wwd_pkg::RELOAD_RST;
         delta <= wwd_pkg::DELTA_RST;
      end else if (wr && !locked && wb_sel_i[1]) begin
         if (hit(wb_adr_i, wwd_pkg::ADDR_CTRL)) begin
            ctrl.en <= wb_dat_i[wwd_pkg::CTRL_EN];
            ctrl.dbg_hold <= wb_dat_i[wwd_pkg::CTRL_DBG_HOLD];
            ctrl.src_ext <= wb_dat_i[wwd_pkg::CTRL_SRC_EXT];
            ctrl.pre_sel <= wb_dat_i[wwd_pkg::CTRL_PRE_LO +: 3];
         end
         if (hit(wb_adr_i, wwd_pkg::ADDR_RELOAD)) begin
            reload <= wb_dat_i[11:0];
         end
         if (hit(wb_adr_i, wwd_pkg::ADDR_DELTA)) begin
            delta <= wb_dat_i[11:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // oscillator and halt synchronisers
   always_ff @(posedge clk) begin
      if (rst) begin
         int_sync <= 2'h0;
         ext_sync <= 2'h0;
         halt_sync <= 2'h0;
         osc_prev <= 1'b0;
      end else begin
         int_sync <= {int_sync[0], low_speed_internal_osc};
         ext_sync <= {ext_sync[0], low_speed_external_osc};
         halt_sync <= {halt_sync[0], cpu_halted};
         osc_prev <= osc_lvl;
      end
   end
   assign osc_lvl = ctrl.src_ext ? ext_sync[1] : int_sync[1];
   assign osc_edge = osc_lvl && !osc_prev;

   ////////////////////////////////////////////////////////////////////////
   // prescaler and counter
   assign pre_lim = 8'((9'h001 << ctrl.pre_sel) - 9'h001);
   assign tick = osc_edge && (pre_cnt == pre_lim)
      && !(ctrl.dbg_hold && halt_sync[1]);

   always_ff @(posedge clk) begin
      if (rst) begin
         pre_cnt <= 8'h00;
      end else if (kick || !ctrl.en) begin
         pre_cnt <= 8'h00;
      end else if (osc_edge && !(ctrl.dbg_hold && halt_sync[1])) begin
         pre_cnt <= (pre_cnt == pre_lim) ? 8'h00 : pre_cnt + 8'h01;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         count <= wwd_pkg::RELOAD_RST;
      end else if (kick || !ctrl.en) begin
         count <= reload;
      end else if (under) begin
         count <= reload;
      end else if (tick) begin
         count <= count - 12'h001;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // reset request, status and interrupt
   always_ff @(posedge clk) begin
      if (rst) begin
         pulse_cnt <= 4'h0;
      end else if ((under || (early && ctrl.en)) && pulse_cnt == 4'h0) begin
         pulse_cnt <= 4'(wwd_pkg::RST_PULSE_CYC);
      end else if (pulse_cnt != 4'h0) begin
         pulse_cnt <= pulse_cnt - 4'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         sys_rst_req <= 1'b0;
      end else begin
         sys_rst_req <= (under || (early && ctrl.en)) || pulse_cnt > 4'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         stat <= '0;
         mask <= wwd_pkg::MASK_RST;
      end else begin
         if (wr && hit(wb_adr_i, wwd_pkg::ADDR_MASK)) begin
            mask <= wb_dat_i[1:0];
         end
         stat.under <= under || (stat.under && !(wr && hit(wb_adr_i, wwd_pkg::ADDR_STAT)
            && wb_dat_i[wwd_pkg::ST_UNDER]));
         stat.early <= (early && ctrl.en) || (stat.early && !(wr
            && hit(wb_adr_i, wwd_pkg::ADDR_STAT) && wb_dat_i[wwd_pkg::ST_EARLY]));
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(stat & mask);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   property p_under_rst;
      @(posedge clk) disable iff (rst) under |=> sys_rst_req;
   endproperty
   a_under_rst: assert property (p_under_rst) else $error("underflow without reset");

   property p_early_rst;
      @(posedge clk) disable iff (rst) (kick && ctrl.en && count > delta) |=> sys_rst_req;
   endproperty
   a_early_rst: assert property (p_early_rst) else $error("early reload not punished");

   property p_good_kick;
      @(posedge clk) disable iff (rst) (kick && ctrl.en && count <= delta && !under
         && pulse_cnt == 4'h0) |=> !sys_rst_req && count == $past(reload);
   endproperty
   a_good_kick: assert property (p_good_kick) else $error("window reload misbehaved");

   property p_dec;
      @(posedge clk) disable iff (rst) (tick && ctrl.en && !kick && count != 12'h000)
         |=> count == $past(count) - 12'h001;
   endproperty
   a_dec: assert property (p_dec) else $error("counter did not step down");

   property p_hold;
      @(posedge clk) disable iff (rst) (ctrl.dbg_hold && halt_sync[1] && !kick
         && ctrl.en && $stable(ctrl)) |=> $stable(count);
   endproperty
   a_hold: assert property (p_hold) else $error("counter moved during debug halt");

   property p_lock;
      @(posedge clk) disable iff (rst) locked && !wr |=> $stable(delta) && $stable(reload);
   endproperty
   a_lock: assert property (p_lock) else $error("locked config changed");

   property p_lock_wr;
      @(posedge clk) disable iff (rst) (locked && wr) |=> $stable(ctrl) && $stable(delta)
         && $stable(reload);
   endproperty
   a_lock_wr: assert property (p_lock_wr) else $error("write passed lock");

   sequence s_delta_wr;
      wr && !locked && wb_sel_i[1] && hit(wb_adr_i, wwd_pkg::ADDR_DELTA);
   endsequence
   property p_delta;
      @(posedge clk) disable iff (rst) s_delta_wr |=> delta == $past(wb_dat_i[11:0]);
   endproperty
   a_delta: assert property (p_delta) else $error("delta not written");

   property p_src;
      @(posedge clk) disable iff (rst) (ctrl.en && ctrl.src_ext && !ext_sync[1] && !kick)
         |=> $stable(count);
   endproperty
   a_src: assert property (p_src) else $error("wrong oscillator");
endmodule

/* File: testbench/wwd_tb.sv */
/*
 self-checking bench for the window watchdog: wishbone register tasks,
 oscillator edge generation and a read-data scoreboard.
 assumes wwd_pkg and wwd_top are compiled first.
*/
`timescale 1ns/1ps
module testbench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] dat = 32'h0;
   logic osc_i = 1'b0;
   logic osc_e = 1'b0;
   logic halt = 1'b0;
   logic [31:0] rdat;
   logic ack;
   logic sreq;
   logic irq;
   logic [11:0] r;
   logic [31:0] q[$];
   int fails = 0;
   int total_checks = 0;
   int hi = 0;
   int nexp = 0;

   always #20 clk = ~clk;

   wwd_top DUT (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .low_speed_internal_osc(osc_i), .low_speed_external_osc(osc_e),
      .cpu_halted(halt), .sys_rst_req(sreq), .irq(irq));

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         fails++;
         $display("mismatch at %0t got %h exp %h", $time, g, e);
      end
   endtask

   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      sel <= 4'hF;
      do begin
         @(posedge clk);
      end while (ack !== 1'b1);
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      q.push_back(e);
      wb(1'b0, a, 32'h0);
   endtask

   // n rising edges on one oscillator pin
   task automatic tick(input logic ext, input int n);
      repeat (n) begin
         @(posedge clk);
         osc_e <= ext;
         osc_i <= ~ext;
         repeat (4) @(posedge clk);
         osc_e <= 1'b0;
         osc_i <= 1'b0;
         repeat (4) @(posedge clk);
      end
   endtask

   // cumulative count of reset-request cycles
   task automatic see_rst(input logic e);
      repeat (16) @(posedge clk);
      if (e) begin
         nexp += wwd_pkg::RST_PULSE_CYC;
      end
      chk(hi, nexp);
   endtask

   task automatic irqchk(input logic e);
      repeat (3) @(posedge clk);
      chk(irq, e);
   endtask

   task automatic results();
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   always @(posedge clk) begin
      if (sreq === 1'b1) begin
         hi++;
      end
      if (ack === 1'b1 && we === 1'b0) begin
         chk(rdat, q.pop_front());
      end
   end

   initial begin
      repeat (30000) @(posedge clk);
      fails++;
      results();
   end

   initial begin
      void'($urandom(32'hB30A));
      r = 12'(3 + $urandom % 6);
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rd(wwd_pkg::ADDR_CTRL, 32'h0);
      rd(wwd_pkg::ADDR_RELOAD, 32'hFFF);
      rd(wwd_pkg::ADDR_DELTA, 32'hFFF);
      rd(wwd_pkg::ADDR_MASK, 32'h3);
      rd(wwd_pkg::ADDR_PROT, 32'h0);
      rd(wwd_pkg::ADDR_STAT, 32'h0);
      wb(1'b1, 8'h20, 32'hFFFF);
      rd(8'h20, 32'h0);
      $display("test reset values done");
      wb(1'b1, wwd_pkg::ADDR_RELOAD, {20'h0, r});
      wb(1'b1, wwd_pkg::ADDR_CTRL, 32'h1);
      rd(wwd_pkg::ADDR_COUNT, {20'h0, r});
      tick(1'b0, r);
      rd(wwd_pkg::ADDR_COUNT, 32'h0);
      see_rst(1'b0);
      tick(1'b0, 1);
      see_rst(1'b1);
      rd(wwd_pkg::ADDR_COUNT, {20'h0, r});
      rd(wwd_pkg::ADDR_STAT, 32'h1);
      irqchk(1'b1);
      wb(1'b1, wwd_pkg::ADDR_STAT, 32'h1);
      rd(wwd_pkg::ADDR_STAT, 32'h0);
      irqchk(1'b0);
      $display("test underflow done");
      wb(1'b1, wwd_pkg::ADDR_DELTA, 32'h2);
      wb(1'b1, wwd_pkg::ADDR_KICK, 32'h5FA0);
      see_rst(1'b1);
      rd(wwd_pkg::ADDR_STAT, 32'h2);
      wb(1'b1, wwd_pkg::ADDR_MASK, 32'h0);
      irqchk(1'b0);
      wb(1'b1, wwd_pkg::ADDR_MASK, 32'h3);
      irqchk(1'b1);
      wb(1'b1, wwd_pkg::ADDR_STAT, 32'h2);
      irqchk(1'b0);
      wb(1'b1, wwd_pkg::ADDR_CTRL, 32'h0);
      wb(1'b1, wwd_pkg::ADDR_CTRL, 32'h1);
      tick(1'b0, r - 2);
      wb(1'b1, wwd_pkg::ADDR_KICK, 32'h5FA0);
      see_rst(1'b0);
      rd(wwd_pkg::ADDR_COUNT, {20'h0, r});
      rd(wwd_pkg::ADDR_STAT, 32'h0);
      $display("test window done");
      wb(1'b1, wwd_pkg::ADDR_PROT, 32'hCA35);
      rd(wwd_pkg::ADDR_PROT, 32'h1);
      wb(1'b1, wwd_pkg::ADDR_DELTA, 32'h7);
      rd(wwd_pkg::ADDR_DELTA, 32'h2);
      wb(1'b1, wwd_pkg::ADDR_PROT, 32'h35CA);
      rd(wwd_pkg::ADDR_PROT, 32'h0);
      wb(1'b1, wwd_pkg::ADDR_DELTA, 32'h7);
      rd(wwd_pkg::ADDR_DELTA, 32'h7);
      $display("test lock done");
      wb(1'b1, wwd_pkg::ADDR_CTRL, 32'h0);
      wb(1'b1, wwd_pkg::ADDR_CTRL, 32'h3);
      halt <= 1'b1;
      repeat (4) @(posedge clk);
      tick(1'b0, 2);
      rd(wwd_pkg::ADDR_COUNT, {20'h0, r});
      halt <= 1'b0;
      repeat (4) @(posedge clk);
      tick(1'b0, 1);
      rd(wwd_pkg::ADDR_COUNT, {20'h0, r - 12'h001});
      wb(1'b1, wwd_pkg::ADDR_CTRL, 32'h0);
      wb(1'b1, wwd_pkg::ADDR_CTRL, 32'h5);
      tick(1'b0, 2);
      rd(wwd_pkg::ADDR_COUNT, {20'h0, r});
      tick(1'b1, 1);
      rd(wwd_pkg::ADDR_COUNT, {20'h0, r - 12'h001});
      wb(1'b1, wwd_pkg::ADDR_CTRL, 32'h0);
      wb(1'b1, wwd_pkg::ADDR_CTRL, 32'h11);
      tick(1'b0, 4);
      rd(wwd_pkg::ADDR_COUNT, {20'h0, r - 12'h002});
      $display("test halt, source and prescale done");
      repeat (4) @(posedge clk);
      results();
   end
endmodule
